// File: host_q_model.sv
`timescale 1ns/100ps
// ****************************************
// host queue model
// ****************************************
module host_q_model (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       go,
  input  wire logic [6:0] rdy_n,
  input  wire logic [6:0] channel_number,
  input  wire logic [7:0] free_n,
  output logic            rdy_valid,
  output logic      [6:0] rdy_channel_number,
  output logic            freed_valid,
  output logic            busy
);
  int         r_left;
  int         f_left;
  logic [6:0] junk;
  // offer one reference per cycle; idle channel lines keep changing
  always @(posedge sys_clk) begin
    junk <= rst_n ? ~junk : 7'h55; // known idle pattern after reset
    if (!rst_n) begin
      r_left <= 0;
      f_left <= 0;
    end else if (go) begin
      r_left <= int'(rdy_n);
      f_left <= int'(free_n);
    end else begin
      r_left <= (r_left > 0) ? r_left - 1 : 0;
      f_left <= (f_left > 0) ? f_left - 1 : 0;
    end
  end
  assign rdy_valid = (r_left > 0);
  assign freed_valid = (f_left > 0);
  assign rdy_channel_number = rdy_valid ? channel_number : junk;
  assign busy = rdy_valid | freed_valid;
endmodule

// File: tb_tx_dma_ctrl.sv
`timescale 1ns/100ps
module tb_tx_dma_ctrl;
  logic sys_clk, rst_n, reg_sel, reg_wr, rdy_valid, rdy_take, go, mbusy;
  logic chain_append, chain_reject, lists_empty, fetch_en, freed_valid;
  logic free_write, rqi, fqi;
  logic [11:0] reg_addr;
  logic [3:0]  be_n;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [6:0]  rdy_channel_number, chain_channel_number, m_n, m_channel_number, exp_channel_number;
  logic [7:0]  m_free;
  logic [2:0]  free_count;
  int n_mismatch, checked, n_take, n_app, n_rej, n_ri, n_fw, n_fs, n_fi;
  int rtab[6] = '{1, 4, 6, 8, 16, 32};
  int ftab[3] = '{1, 4, 8};
  tx_dma_ctrl uut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_sel(reg_sel),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .byte_lane_enables_n(be_n),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rdy_valid(rdy_valid),
    .rdy_channel_number(rdy_channel_number), .rdy_take(rdy_take), .chain_append(chain_append),
    .chain_reject(chain_reject), .chain_channel_number(chain_channel_number),
    .lists_empty(lists_empty), .fetch_en(fetch_en),
    .freed_valid(freed_valid), .free_write(free_write),
    .free_count(free_count), .ready_queue_interrupt(rqi),
    .free_queue_interrupt(fqi));
  host_q_model host (.sys_clk(sys_clk), .rst_n(rst_n), .go(go),
    .rdy_n(m_n), .channel_number(m_channel_number), .free_n(m_free), .rdy_valid(rdy_valid),
    .rdy_channel_number(rdy_channel_number), .freed_valid(freed_valid), .busy(mbusy));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // tally the device's pulses, checking the channel of each verdict
  always @(posedge sys_clk) begin
    n_take += rdy_take;
    n_app += chain_append;
    n_rej += chain_reject;
    n_ri += rqi;
    n_fw += free_write;
    n_fs += free_write ? free_count : 0;
    n_fi += fqi;
    if (chain_append | chain_reject) check(chain_channel_number, exp_channel_number);
  end
  task automatic acc(input logic w, input logic [11:0] a,
                     input logic [31:0] v, input logic [3:0] b);
    @(posedge sys_clk);
    reg_sel <= 1;
    reg_wr <= w;
    reg_addr <= a;
    reg_wdata <= v;
    be_n <= b;
    @(posedge sys_clk);
    reg_sel <= 0;
    #1 d = reg_rdata;
  endtask
  task automatic idle_wait;
    acc(0, 12'h304, 0, 0);
    for (int i = 0; i < 20 && d[15] !== 1'b0; i++) acc(0, 12'h304, 0, 0);
    check(d[15], 0);
  endtask
  task automatic run(input int nr, input int nf, input logic [6:0] c);
    n_take = 0; n_app = 0; n_rej = 0; n_ri = 0; n_fw = 0; n_fs = 0; n_fi = 0;
    exp_channel_number = c;
    @(posedge sys_clk);
    go <= 1;
    m_n <= nr[6:0];
    m_free <= nf[7:0];
    m_channel_number <= c;
    @(posedge sys_clk);
    go <= 0;
    @(posedge sys_clk);
    for (int i = 0; i < 300 && mbusy !== 1'b0; i++) @(posedge sys_clk);
    check(mbusy, 0);
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic t_regs;
    acc(0, 12'h300, 0, 0);
    check(d[6:0], 7'h02);
    acc(1, 12'h304, 32'h0000_0085, 4'b1101);
    acc(0, 12'h304, 0, 0);
    check(d[15], 1);
    check(d[7:0], 8'h85);
    idle_wait;
    acc(1, 12'h304, 32'h0000_0009, 4'b1111);
    acc(0, 12'h304, 0, 0);
    check(d[7:0], 8'h85);
    acc(1, 12'h304, 32'h0000_4089, 0);
    idle_wait;
    check(d[7:0], 8'h09);
    acc(1, 12'h304, 32'h0000_4005, 0);
    idle_wait;
    check(d[7:0], 8'h85);
  endtask
  task automatic t_ready;
    for (int k = 0; k < 6; k++) begin
      acc(1, 12'h300, (k << 2) | 3, 0);
      run(rtab[k], 0, 7'h05);
      check(n_take, rtab[k]);
      check(n_app, rtab[k]);
      check(n_ri, 1);
      check(fetch_en, 1);
    end
    acc(1, 12'h300, 32'h0000_0003, 0);
    run(2, 0, 7'h09);
    check(n_rej, 2);
    check(n_ri, 2);
  endtask
  task automatic t_off;
    acc(1, 12'h300, 32'h0000_0002, 0);
    lists_empty <= 0;
    run(3, 0, 7'h05);
    check(n_take, 0);
    check(n_rej, 0);
    check(fetch_en, 1);
    lists_empty <= 1;
    repeat (4) @(posedge sys_clk);
    check(fetch_en, 0);
  endtask
  task automatic t_free;
    for (int k = 0; k < 3; k++) begin
      acc(1, 12'h300, (k << 5) | 2, 0);
      run(0, 6 * ftab[k], 7'h05);
      check(n_fw, ftab[k]);
      check(n_fs, 6 * ftab[k]);
      check(n_fi, 1);
    end
    acc(1, 12'h300, 0, 0);
    run(0, 3, 7'h05);
    check(n_fw, 3);
    check(n_fs, 3);
    check(n_fi, 3);
  endtask
  task automatic tally_and_finish;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    sys_clk = 0;
    forever #50 sys_clk = ~sys_clk;
  end
  initial begin
    #2000000;
    n_mismatch++;
    tally_and_finish;
  end
  initial begin
    {rst_n, reg_sel, reg_wr, go, reg_addr, reg_wdata, m_n, m_channel_number} = 0;
    {be_n, m_free, exp_channel_number, lists_empty} = {4'hf, 15'h0000, 1'b1};
    repeat (2) @(posedge sys_clk);
    rst_n <= 1;
    t_regs;
    t_ready;
    t_off;
    t_free;
    tally_and_finish;
  end
endmodule

// File: tx_dma_ctrl.sv
`timescale 1ns/100ps
module tx_dma_ctrl (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // host register port
  input  wire logic        reg_sel,
  input  wire logic        reg_wr,
  input  wire logic [11:0] reg_addr,
  input  wire logic [3:0]  byte_lane_enables_n,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  // ready queue of descriptor references
  input  wire logic        rdy_valid,
  input  wire logic [6:0]  rdy_channel_number,
  output logic             rdy_take,
  // chain verdict
  output logic             chain_append,
  output logic             chain_reject,
  output logic      [6:0]  chain_channel_number,
  // data fetch and link activity
  input  wire logic        lists_empty,
  output logic             fetch_en,
  // freed references
  input  wire logic        freed_valid,
  output logic             free_write,
  output logic      [2:0]  free_count,
  // interrupts
  output logic             ready_queue_interrupt,
  output logic             free_queue_interrupt
);
  // ****************************************
  // state and registers
  // ****************************************
  typedef enum logic [1:0] {
    IDLE_S = 2'b00,
    BUSY_S = 2'b01,
    DONE_S = 2'b10
  } acc_e;

  acc_e        acc_reg, acc_next;
  logic [6:0]  ctrl_reg;
  logic [6:0]  channel_number_reg;
  logic        flag_reg;
  logic        rws_reg;
  logic [1:0]  wait_reg;
  logic [5:0]  rdy_cnt_reg;
  logic [3:0]  free_blk_reg;
  logic [2:0]  cache_reg;
  logic        mem_rd_flag;
  logic        chk_flag;
  logic        en_s1_reg;

  // ready-count code to reference count
  function automatic logic [5:0] rdy_thresh(input logic [2:0] code);
    case (code)
      3'h0: rdy_thresh = 6'h01;
      3'h1: rdy_thresh = 6'h04;
      3'h2: rdy_thresh = 6'h06;
      3'h3: rdy_thresh = 6'h08;
      3'h4: rdy_thresh = 6'h10;
      default: rdy_thresh = 6'h20; // reserved codes undefined
    endcase
  endfunction

  // free-count code to block count
  function automatic logic [3:0] free_thresh(input logic [1:0] code);
    case (code)
      2'h0: free_thresh = 4'h1;
      2'h1: free_thresh = 4'h4;
      default: free_thresh = 4'h8; // reserved code undefined
    endcase
  endfunction

  // ****************************************
  // decode
  // ****************************************
  wire any_lane  = ~&byte_lane_enables_n;
  wire ctrl_hit  = reg_sel && any_lane
                   && reg_addr == tx_dma_pkg::CTRL_OFFSET;
  wire provision_flag_hit  = reg_sel && any_lane
                   && reg_addr == tx_dma_pkg::PROVISION_FLAG_OFFSET;
  wire ctrl_wr   = ctrl_hit && reg_wr;
  wire provision_flag_wr   = provision_flag_hit && reg_wr && acc_reg == IDLE_S;
  wire enable    = ctrl_reg[tx_dma_pkg::ENABLE_BIT];
  wire cache_on  = ctrl_reg[tx_dma_pkg::CACHE_BIT];
  wire [2:0] rdy_code  = ctrl_reg[tx_dma_pkg::RDY_LSB +: 3];
  wire [1:0] free_code = ctrl_reg[tx_dma_pkg::FREE_LSB +: 2];
  wire take      = enable && rdy_valid;
  wire rdy_hit   = take && (rdy_cnt_reg + 6'h01 >= rdy_thresh(rdy_code));
  wire [2:0] blk_size = cache_on ? tx_dma_pkg::CACHE_BLOCK : 3'h1;
  wire cache_full = freed_valid && (cache_reg + 3'h1 >= blk_size);
  wire free_hit  = cache_full
                   && (free_blk_reg + 4'h1 >= free_thresh(free_code));
  wire mem_wr    = acc_reg == BUSY_S && wait_reg == '0 && !rws_reg;
  wire rd_done   = acc_reg == BUSY_S && wait_reg == '0 && rws_reg;

  // ****************************************
  // control register
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_reg <= tx_dma_pkg::CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_reg <= reg_wdata[6:0];
    end
  end

  // ****************************************
  // indirect provisioning access
  // ****************************************
  always_comb begin
    acc_next = acc_reg;
    unique case (acc_reg)
      IDLE_S: if (provision_flag_wr) acc_next = BUSY_S;
      BUSY_S: if (wait_reg == '0) acc_next = DONE_S;
      DONE_S: acc_next = IDLE_S;
      default: acc_next = IDLE_S;
    endcase
  end

  // provisioning fields; whole word taken on any lane
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      acc_reg  <= IDLE_S;
      channel_number_reg <= '0;
      flag_reg <= 1'b0;
      rws_reg  <= 1'b0;
      wait_reg <= '0;
    end else begin
      acc_reg <= acc_next;
      if (provision_flag_wr) begin
        channel_number_reg <= reg_wdata[tx_dma_pkg::CHANNEL_NUMBER_W-1:0];
        flag_reg <= reg_wdata[tx_dma_pkg::PROVISION_FLAG_FLAG_BIT];
        rws_reg  <= reg_wdata[tx_dma_pkg::RWS_BIT];
        wait_reg <= tx_dma_pkg::ACCESS_CYCLES;
      end else if (acc_reg == BUSY_S && wait_reg != '0) begin
        wait_reg <= wait_reg - 2'h1;
      end
      if (rd_done) begin
        flag_reg <= mem_rd_flag;
      end
    end
  end

  tx_provision_flag_mem u_mem (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .wr_en    (mem_wr),
    .wr_channel_number  (channel_number_reg),
    .wr_flag  (flag_reg),
    .rd_channel_number  (channel_number_reg),
    .rd_flag  (mem_rd_flag),
    .chk_channel_number (rdy_channel_number),
    .chk_flag (chk_flag)
  );

  // ****************************************
  // ready queue, chains, counters
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdy_take     <= 1'b0;
      chain_append <= 1'b0;
      chain_reject <= 1'b0;
      chain_channel_number   <= '0;
      rdy_cnt_reg  <= '0;
      ready_queue_interrupt <= 1'b0;
    end else begin
      rdy_take     <= take;
      chain_append <= take && chk_flag;
      chain_reject <= take && !chk_flag;
      chain_channel_number   <= rdy_channel_number;
      ready_queue_interrupt <= rdy_hit;
      if (take) begin
        rdy_cnt_reg <= rdy_hit ? 6'h00 : rdy_cnt_reg + 6'h01;
      end
    end
  end

  // free reference cache and block counter
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cache_reg    <= '0;
      free_blk_reg <= '0;
      free_write   <= 1'b0;
      free_count   <= '0;
      free_queue_interrupt <= 1'b0;
    end else begin
      free_write <= cache_full;
      free_count <= cache_reg + 3'h1;
      free_queue_interrupt <= free_hit;
      if (freed_valid) begin
        cache_reg <= cache_full ? 3'h0 : cache_reg + 3'h1;
      end
      if (cache_full) begin
        free_blk_reg <= free_hit ? 4'h0 : free_blk_reg + 4'h1;
      end
    end
  end

  // fetch continues until built lists drain
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      en_s1_reg <= 1'b0;
      fetch_en  <= 1'b0;
    end else begin
      en_s1_reg <= enable;
      fetch_en  <= en_s1_reg || !lists_empty;
    end
  end

  // ****************************************
  // read data
  // ****************************************
  wire [31:0] ctrl_word = {25'h0, ctrl_reg};
  wire [31:0] provision_flag_word = {16'h0, acc_reg != IDLE_S, rws_reg, 6'h0,
                           flag_reg, channel_number_reg};
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= ctrl_hit ? ctrl_word : provision_flag_hit ? provision_flag_word : 32'h0;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  busy_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    provision_flag_wr |=> acc_reg == BUSY_S [*3])
    else $error("busy not held during access");
  no_take_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !enable |=> !rdy_take)
    else $error("reference taken while disabled");
  verdict_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    take |=> chain_append != chain_reject)
    else $error("chain verdict wrong");
  reject_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    take && !chk_flag |=> chain_reject)
    else $error("unprovisioned chain not rejected");
  single_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    freed_valid && !cache_on |=> free_write)
    else $error("uncached reference not written");
  block_six_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    free_write && $past(cache_on) |-> free_count <= 3'h6)
    else $error("cached block too large");
  no_lane_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_sel && reg_wr && &byte_lane_enables_n |=> $stable(ctrl_reg))
    else $error("access made with no lanes");
  channel_number_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    acc_reg == BUSY_S |=> $stable(channel_number_reg))
    else $error("channel field changed mid access");
  rdy_one_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    take && rdy_code == 3'h0 |=> ready_queue_interrupt)
    else $error("ready interrupt missing");
  free_one_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cache_full && free_code == 2'h0 |=> free_queue_interrupt)
    else $error("free interrupt missing");
  query_c: cover property (@(posedge sys_clk) rd_done);
  provision_flag_c: cover property (@(posedge sys_clk) mem_wr && flag_reg);
  reject_c: cover property (@(posedge sys_clk) chain_reject);
  block_c: cover property (@(posedge sys_clk)
    free_write && free_count == 3'h6);
endmodule

// File: tx_dma_pkg.sv
package tx_dma_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [11:0] CTRL_OFFSET = 12'h0300;
  localparam logic [11:0] PROVISION_FLAG_OFFSET = 12'h0304;
  // control fields
  localparam int ENABLE_BIT    = 0;
  localparam int CACHE_BIT     = 1;
  localparam int RDY_LSB       = 2;
  localparam int FREE_LSB      = 5;
  localparam logic [6:0] CTRL_RESET = 7'h02;
  // provisioning fields
  localparam int PROVISION_FLAG_FLAG_BIT = 7;
  localparam int RWS_BIT       = 14;
  localparam int BUSY_BIT      = 15;
  // free-queue block size when caching
  localparam logic [2:0] CACHE_BLOCK = 3'h6;
  // indirect access latency in cycles
  localparam logic [1:0] ACCESS_CYCLES = 2'h2;
  // channel memory size
  localparam int CHANNELS = 128;
  localparam int CHANNEL_NUMBER_W   = 7;
endpackage

// File: tx_provision_flag_mem.sv
`timescale 1ns/100ps
// ****************************************
// channel provisioning memory
// ****************************************
module tx_provision_flag_mem (
  input  wire logic                           sys_clk,
  input  wire logic                           rst_n,
  input  wire logic                           wr_en,
  input  wire logic [tx_dma_pkg::CHANNEL_NUMBER_W-1:0]  wr_channel_number,
  input  wire logic                           wr_flag,
  input  wire logic [tx_dma_pkg::CHANNEL_NUMBER_W-1:0]  rd_channel_number,
  output logic                                rd_flag,
  input  wire logic [tx_dma_pkg::CHANNEL_NUMBER_W-1:0]  chk_channel_number,
  output logic                                chk_flag
);
  logic [tx_dma_pkg::CHANNELS-1:0] provision_flag_reg;

  // one flag per channel, all unprovisioned at reset
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      provision_flag_reg <= '0;
    end else if (wr_en) begin
      provision_flag_reg[wr_channel_number] <= wr_flag;
    end
  end

  // read ports
  assign rd_flag  = provision_flag_reg[rd_channel_number];
  assign chk_flag = provision_flag_reg[chk_channel_number];
endmodule
